// ==== include/dtc_pkg.sv ====
// constants, types and sizing helpers of the dither / taylor correction stage
// assumes one core clock; all widths below are the documented defaults
`default_nettype none
package dtc_pkg;
   // datapath widths
   localparam int ACC_W_DEF = 32;         // accumulator phase width
   localparam int ADDR_W_DEF = 12;        // table address width, 4096 deep
   localparam int TBL_W_DEF = 18;         // stored sample width
   localparam int OUT_GROW = 2;           // corrected path is two bits wider
   localparam int FIFO_DEPTH_DEF = 8;
   // phase error square memory
   localparam int SQ_IW = 8;              // index bits taken from the fraction
   localparam int SQ_W = 17;              // stored width of scaled square
   localparam int SQ_Q = 12;              // fractional bits of stored square
   localparam logic [63:0] HALF_TWO_PI_SQ_Q12 = 64'h0000_0000_0001_3bd4; // (2pi)^2/2
   localparam logic [19:0] TWO_PI_Q16 = 20'h6487f;                      // 2pi in q16
   localparam int TWO_PI_FRAC = 16;
   // dither source
   localparam int LFSR_W = 32;
   localparam logic [31:0] LFSR_SEED = 32'hace1_2f5b;
   localparam logic [31:0] LFSR_TAPS = 32'h8020_0003;
   // spur budget figures in dB
   localparam int SFDR_DB_DEF = 70;
   localparam int DB_PER_BIT = 6;
   localparam int DITHER_SAVE_BITS = 2;
   localparam int DITHER_GAIN_DB = 12;
   localparam int SINGLE_TBL_DB = 102;
   localparam int LIN_LIMIT_DB = 118;
   localparam int QUAD_LIMIT_DB = 150;

   typedef enum logic [1:0] {
      MODE_TRUNC = 2'h0,
      MODE_DITHER = 2'h1,
      MODE_LINEAR = 2'h2,
      MODE_QUAD = 2'h3
   } dtc_mode_type;

   typedef enum logic [1:0] {
      ST_INIT = 2'b01,
      ST_RUN = 2'b10
   } dtc_state_type;

   // least table address bits for a spur target, dithered or plain
   function automatic int dtc_addr_bits(input int sfdr_db, input bit dithered);
      int bits;
      bits = (sfdr_db + DB_PER_BIT - 1) / DB_PER_BIT;
      if (dithered) begin
         bits = bits - DITHER_SAVE_BITS;
      end
      return bits;
   endfunction
endpackage
`default_nettype wire

// ==== include/dtc_stream_if.sv ====
// valid/ready word stream between the stage's own modules
// assumes both ends run on core_clk
`timescale 1ns/1ns
`default_nettype none
interface dtc_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== rtl/dtc_fifo.sv ====
// small synchronous fifo, registered full/empty flags
// assumes a single clock and a synchronous active low reset
`timescale 1ns/1ns
`default_nettype none
module dtc_fifo #(
   parameter int W = 32,
   parameter int DEPTH = 8
) (
   input wire logic core_clk,
   input wire logic reset_n,
   dtc_stream_if.snk wr,
   dtc_stream_if.src rd
);
   import dtc_pkg::*;
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [PW:0] cnt;
      logic full;
      logic empty;
   } dtc_fifo_state_type;

   dtc_fifo_state_type s_reg, s_next;
   logic push, pop;

   // flags are registered so the upstream ready never passes through logic
   always_comb begin
      s_next = s_reg;
      push = wr.valid && !s_reg.full;
      pop = rd.ready && !s_reg.empty;
      if (push) begin
         s_next.mem[s_reg.wp] = wr.data;
         s_next.wp = (s_reg.wp == PW'(DEPTH - 1)) ? '0 : s_reg.wp + 1'b1;
      end
      if (pop) begin
         s_next.rp = (s_reg.rp == PW'(DEPTH - 1)) ? '0 : s_reg.rp + 1'b1;
      end
      s_next.cnt = s_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
      s_next.full = (s_next.cnt == (PW+1)'(DEPTH));
      s_next.empty = (s_next.cnt == '0);
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         s_reg <= '0;
         s_reg.empty <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign wr.ready = !s_reg.full;
   assign rd.valid = !s_reg.empty;
   assign rd.data = s_reg.mem[s_reg.rp];

   // count never leaves its range
   fifo_bound_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_reg.cnt <= (PW+1)'(DEPTH))
      else $error("fifo count above depth");
endmodule // dtc_fifo
`default_nettype wire

// ==== rtl/dtc_top.sv ====
// spur reduction stage: truncation, phase dither or taylor correction
// assumes phase words from an accumulator on core_clk and a consumer
// that takes sine/cosine samples with valid/ready
//
// Functional notes
// - truncate mode: table address is the integer part of the phase
// - dither mode: add random word to full phase before truncating
// - dither noise spans about one least integer phase bit
// - plain truncation needs at least ceil(S/6) address bits
// - with dither the table needs ceil(S/6) minus two address bits
// - dither buys about 12 dB and whitens spurs into noise
// - correction mode: fraction bits times multipliers added to table sample
// - corrected output two bits wider than stored sample, 18 gives 20
// - linear correction reaches 118 dB, one table, three multipliers
// - quadratic term up to 150 dB, extra multiplier each, square memory
// - sized to guarantee target; above 102 dB uses extra memory
`timescale 1ns/1ns
`default_nettype none
module dtc_top #(
   parameter int ACC_W = dtc_pkg::ACC_W_DEF,
   parameter int ADDR_W = dtc_pkg::ADDR_W_DEF,
   parameter int TBL_W = dtc_pkg::TBL_W_DEF,
   parameter int SFDR_DB = dtc_pkg::SFDR_DB_DEF,
   parameter int FIFO_DEPTH = dtc_pkg::FIFO_DEPTH_DEF
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [ACC_W-1:0] phase_in,
   input wire logic phase_valid,
   output logic phase_ready,
   input wire dtc_pkg::dtc_mode_type mode,
   input wire logic tbl_we,
   input wire logic [ADDR_W-1:0] tbl_addr,
   input wire logic [TBL_W-1:0] tbl_data,
   output logic [TBL_W+dtc_pkg::OUT_GROW-1:0] sin_out,
   output logic [TBL_W+dtc_pkg::OUT_GROW-1:0] cos_out,
   output logic out_valid,
   input wire logic out_ready
);
   import dtc_pkg::*;
   localparam int FRAC_W = ACC_W - ADDR_W;
   localparam int OUT_W = TBL_W + OUT_GROW;
   localparam int DEPTH = 2 ** ADDR_W;
   localparam int SH_LIN = FRAC_W + TWO_PI_FRAC + ADDR_W - OUT_GROW;
   localparam int SH_QUAD = SQ_Q + 2 * ADDR_W - OUT_GROW;
   localparam logic [ADDR_W-1:0] QUARTER = ADDR_W'(DEPTH / 4);

   typedef struct packed {
      dtc_state_type st;
      logic [SQ_IW-1:0] sq_idx;
      logic [2**SQ_IW-1:0][SQ_W-1:0] sq_mem;
      logic [DEPTH-1:0][TBL_W-1:0] tbl;
      logic [LFSR_W-1:0] lfsr;
      logic s1_v;
      dtc_mode_type s1_mode;
      logic [ADDR_W-1:0] s1_addr;
      logic [FRAC_W-1:0] s1_frac;
      logic s2_v;
      dtc_mode_type s2_mode;
      logic [TBL_W-1:0] s2_sin;
      logic [TBL_W-1:0] s2_cos;
      logic [FRAC_W-1:0] s2_frac;
      logic [SQ_W-1:0] s2_sq;
      logic o_v;
      logic [OUT_W-1:0] o_sin;
      logic [OUT_W-1:0] o_cos;
   } dtc_top_state_type;

   dtc_top_state_type s_reg, s_next;
   logic adv;
   logic [ACC_W-1:0] dither, psum;
   logic [63:0] odd, sq_full;
   logic signed [63:0] sin64, cos64, ex, sq64, lin_s, lin_c, quad_s, quad_c;

   dtc_stream_if #(.W(ACC_W)) in_s ();
   dtc_stream_if #(.W(ACC_W)) out_s ();

   // eight-word buffer in front of the pipeline; its full flag stalls the accumulator
   dtc_fifo #(.W(ACC_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .wr(in_s.snk),
      .rd(out_s.src)
   );

   assign in_s.valid = phase_valid;
   assign in_s.data = phase_in;
   assign phase_ready = in_s.ready;
   assign out_s.ready = adv;

   // whole pipeline moves together; the buffer absorbs consumer stalls
   always_comb begin
      s_next = s_reg;
      adv = (s_reg.st == ST_RUN) && (!s_reg.o_v || out_ready);
      dither = '0;
      psum = '0;
      odd = '0;
      sq_full = '0;
      sin64 = 64'(signed'(s_reg.s2_sin));
      cos64 = 64'(signed'(s_reg.s2_cos));
      ex = signed'(64'(s_reg.s2_frac) * 64'(TWO_PI_Q16));
      sq64 = signed'(64'(s_reg.s2_sq));
      lin_s = (cos64 * ex) >>> SH_LIN;
      lin_c = -((sin64 * ex) >>> SH_LIN);
      quad_s = (sin64 * sq64) >>> SH_QUAD;
      quad_c = (cos64 * sq64) >>> SH_QUAD;
      // table is loaded by the user; loading while running gives mixed samples
      if (tbl_we) begin
         s_next.tbl[tbl_addr] = tbl_data;
      end
      // free running noise keeps successive address errors uncorrelated
      s_next.lfsr = {s_reg.lfsr[LFSR_W-2:0], ^(s_reg.lfsr & LFSR_TAPS)};
      case (s_reg.st)
         ST_INIT: begin
            // fill scaled square of the phase error, one entry per clock
            odd = {55'h0, s_reg.sq_idx, 1'b1};
            sq_full = (odd * odd * HALF_TWO_PI_SQ_Q12) >> (2 * (SQ_IW + 1));
            s_next.sq_mem[s_reg.sq_idx] = sq_full[SQ_W-1:0];
            s_next.sq_idx = s_reg.sq_idx + 1'b1;
            if (&s_reg.sq_idx) begin
               s_next.st = ST_RUN;
            end
         end
         ST_RUN: begin
         end
         default: begin
            s_next.st = ST_INIT;
         end
      endcase
      if (adv) begin
         // stage 1: optional dither, then drop the fraction from the address
         dither = {{ADDR_W{1'b0}}, s_reg.lfsr[LFSR_W-1 -: FRAC_W]};
         psum = out_s.data + ((mode == MODE_DITHER) ? dither : '0);
         s_next.s1_v = out_s.valid;
         s_next.s1_mode = mode;
         s_next.s1_addr = psum[ACC_W-1 -: ADDR_W];
         s_next.s1_frac = out_s.data[FRAC_W-1:0];
         // stage 2: table reads, cosine a quarter turn ahead
         s_next.s2_v = s_reg.s1_v;
         s_next.s2_mode = s_reg.s1_mode;
         s_next.s2_sin = s_reg.tbl[s_reg.s1_addr];
         s_next.s2_cos = s_reg.tbl[s_reg.s1_addr + QUARTER];
         s_next.s2_frac = s_reg.s1_frac;
         s_next.s2_sq = s_reg.sq_mem[s_reg.s1_frac[FRAC_W-1 -: SQ_IW]];
         // stage 3: widen, then add taylor terms
         s_next.o_v = s_reg.s2_v;
         s_next.o_sin = OUT_W'(sin64 <<< OUT_GROW);
         s_next.o_cos = OUT_W'(cos64 <<< OUT_GROW);
         if (s_reg.s2_mode == MODE_LINEAR || s_reg.s2_mode == MODE_QUAD) begin
            s_next.o_sin = s_next.o_sin + OUT_W'(lin_s);
            s_next.o_cos = s_next.o_cos + OUT_W'(lin_c);
         end
         if (s_reg.s2_mode == MODE_QUAD) begin
            s_next.o_sin = s_next.o_sin - OUT_W'(quad_s);
            s_next.o_cos = s_next.o_cos - OUT_W'(quad_c);
         end
      end
   end

   // the sample table is cleared by reset as well
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         s_reg <= '0;
         s_reg.st <= ST_INIT;
         s_reg.lfsr <= LFSR_SEED;
      end else begin
         s_reg <= s_next;
      end
   end

   assign sin_out = s_reg.o_sin;
   assign cos_out = s_reg.o_cos;
   assign out_valid = s_reg.o_v;

   trunc_addr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      adv && out_s.valid && mode == MODE_TRUNC
      |=> s_reg.s1_addr == $past(out_s.data[ACC_W-1 -: ADDR_W]))
      else $error("truncated address is not the integer phase");
   dither_addr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      adv && out_s.valid && mode == MODE_DITHER
      |=> s_reg.s1_addr == $past(psum[ACC_W-1 -: ADDR_W]) && $past(dither) != '0)
      else $error("dither not applied before truncation");
   // the seed is held through reset, so the first edge after release shows no step yet
   noise_alive_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      $past(reset_n) |-> s_reg.lfsr != '0 && s_reg.lfsr != $past(s_reg.lfsr))
      else $error("dither source stuck");
   tbl_depth_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      ADDR_W >= dtc_addr_bits(SFDR_DB, 1'b0)
      || (mode == MODE_DITHER && ADDR_W >= dtc_addr_bits(SFDR_DB - DITHER_GAIN_DB, 1'b0))
      || mode == MODE_LINEAR || mode == MODE_QUAD)
      else $error("table too shallow for spur target");
   lin_range_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      (mode == MODE_LINEAR |-> SFDR_DB <= LIN_LIMIT_DB) and (SFDR_DB <= QUAD_LIMIT_DB))
      else $error("spur target beyond correction limit");
   lin_sin_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      adv && s_reg.s2_v && s_reg.s2_mode == MODE_LINEAR
      |=> out_valid && sin_out == $past(OUT_W'(sin64 <<< OUT_GROW) + OUT_W'(lin_s)))
      else $error("linear correction missing on sine");
   plain_wide_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      adv && s_reg.s2_v && s_reg.s2_mode == MODE_TRUNC
      |=> cos_out[OUT_GROW-1:0] == '0 && cos_out[OUT_W-1 -: TBL_W] == $past(s_reg.s2_cos))
      else $error("uncorrected sample not widened");
   init_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_reg.st == ST_INIT |-> !adv ##0 !out_valid)
      else $error("samples issued before square memory filled");
   out_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      out_valid && !out_ready |=> out_valid && $stable(sin_out) && $stable(cos_out))
      else $error("output changed while stalled");
endmodule // dtc_top
`default_nettype wire

// ==== tb/dtc_far_end.sv ====
// far-end model: phase source upstream and sample consumer downstream
// assumes the stage's valid/ready ports on core_clk, driven 2 ns after the edge
`timescale 1ns/1ns
`default_nettype none
module dtc_far_end (
   input wire logic core_clk,
   input wire logic phase_ready,
   input wire logic out_valid,
   input wire logic [19:0] sin_out,
   input wire logic [19:0] cos_out,
   output logic [31:0] phase_in,
   output logic phase_valid,
   output logic out_ready,
   output logic timed_out
);
   initial begin
      phase_in = 32'h0;
      phase_valid = 1'b0;
      out_ready = 1'b0;
      timed_out = 1'b0;
   end
   // offer one word, held until the edge that takes it; valid stays up for back to back
   task automatic push(input logic [31:0] w);
      int n;
      n = 0;
      phase_in = w;
      phase_valid = 1'b1;
      while (phase_ready !== 1'b1 && n < 500) begin
         @(posedge core_clk) #2;
         n++;
      end
      if (n == 500) timed_out = 1'b1;
      @(posedge core_clk) #2;
   endtask
   // released data shows the inverse so a stale word never looks fresh
   task automatic idle();
      phase_valid = 1'b0;
      phase_in = ~phase_in;
   endtask
   // take one sample pair; ready stays up until stall is called
   task automatic pull(output logic [19:0] s, output logic [19:0] c);
      int n;
      n = 0;
      out_ready = 1'b1;
      while (out_valid !== 1'b1 && n < 500) begin
         @(posedge core_clk) #2;
         n++;
      end
      if (n == 500) timed_out = 1'b1;
      s = sin_out;
      c = cos_out;
      @(posedge core_clk) #2;
   endtask
   task automatic stall();
      out_ready = 1'b0;
   endtask
endmodule // dtc_far_end
`default_nettype wire

// ==== tb/tb_dds_dither_taylor_correction.sv ====
// self-checking bench of the spur reduction stage in all four modes
// assumes default widths: 32 bit phase, 12 bit address, 18 bit table, 20 bit out
`timescale 1ns/1ns
`default_nettype none
module tb_dds_dither_taylor_correction;
   import dtc_pkg::*;
   logic core_clk, reset_n, phase_ready, phase_valid, out_valid, out_ready, tbl_we, timed_out;
   logic [31:0] phase_in;
   logic [11:0] tbl_addr;
   logic [17:0] tbl_data;
   logic [19:0] sin_out, cos_out, s, c;
   dtc_mode_type mode;
   int bad_count = 0;
   int cmp_count = 0;
   dtc_top dut (.core_clk(core_clk), .reset_n(reset_n), .phase_in(phase_in),
      .phase_valid(phase_valid), .phase_ready(phase_ready), .mode(mode), .tbl_we(tbl_we),
      .tbl_addr(tbl_addr), .tbl_data(tbl_data), .sin_out(sin_out), .cos_out(cos_out),
      .out_valid(out_valid), .out_ready(out_ready));
   dtc_far_end far (.core_clk(core_clk), .phase_ready(phase_ready), .out_valid(out_valid),
      .sin_out(sin_out), .cos_out(cos_out), .phase_in(phase_in), .phase_valid(phase_valid),
      .out_ready(out_ready), .timed_out(timed_out));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // ramp table: every address gives a distinct signed sample
   function automatic longint ent(input int i);
      return longint'((i % 4096) * 32 - 65536);
   endfunction
   // expected output; a tolerance absorbs rounding of the correction terms
   function automatic logic [19:0] expv(input logic [31:0] ph, input bit cosv);
      longint sv, cv, o, d, r, f, sq;
      sv = ent(int'(ph[31:20]));
      cv = ent(int'(ph[31:20]) + 1024);
      f = longint'(ph[19:0]);
      sq = (longint'(HALF_TWO_PI_SQ_Q12) * longint'(ph[19:12]) * longint'(ph[19:12])) >>> 16;
      o = cosv ? cv : sv;
      d = cosv ? -sv : cv;
      r = o * 4;
      if (mode == MODE_LINEAR || mode == MODE_QUAD) r = r + ((d * f * longint'(TWO_PI_Q16)) >>> 46);
      if (mode == MODE_QUAD) r = r - ((o * sq) >>> 34);
      return r[19:0];
   endfunction
   task automatic chk(input logic [19:0] got, input logic [19:0] exp, input int tol);
      logic signed [19:0] d;
      d = got - exp;
      cmp_count++;
      if (got !== exp && !(tol > 0 && (d >= -tol) === 1'b1 && (d <= tol) === 1'b1)) begin
         bad_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // n words back to back, then drained in order and compared
   task automatic burst(input dtc_mode_type m, input logic [31:0] base, input int n, input int tol);
      mode = m;
      for (int k = 0; k < n; k++) far.push(base + k * 32'h2a5c_3b71);
      far.idle();
      for (int k = 0; k < n; k++) begin
         far.pull(s, c);
         chk(s, expv(base + k * 32'h2a5c_3b71, 1'b0), tol);
         chk(c, expv(base + k * 32'h2a5c_3b71, 1'b1), tol);
      end
      far.stall();
   endtask
   // consumer stalls: buffer fills until refused, output holds, then drains in order
   task automatic fill();
      int n;
      logic [19:0] h;
      n = 0;
      mode = MODE_TRUNC;
      while (phase_ready === 1'b1 && n < 40) begin
         far.push(32'h1234_5678 + n * 32'h0110_0000);
         n++;
      end
      far.idle();
      chk(20'(n >= 8 && n < 40), 20'h1, 0);
      h = sin_out;
      repeat (3) @(posedge core_clk) #2;
      chk(sin_out, h, 0);
      chk(20'(out_valid), 20'h1, 0);
      for (int k = 0; k < n; k++) begin
         far.pull(s, c);
         chk(s, expv(32'h1234_5678 + k * 32'h0110_0000, 1'b0), 0);
      end
      far.stall();
      chk(20'(phase_ready), 20'h1, 0);
   endtask
   // half-lsb fraction: dithered address lands on both neighbours, never elsewhere
   task automatic dith();
      int up;
      up = 0;
      mode = MODE_DITHER;
      for (int r = 0; r < 4; r++) begin
         for (int k = 0; k < 4; k++) far.push({12'd100, 20'h80000});
         far.idle();
         for (int k = 0; k < 4; k++) begin
            far.pull(s, c);
            if (s === 20'(ent(101) * 4)) up++;
            else chk(s, 20'(ent(100) * 4), 0);
         end
         far.stall();
      end
      chk(20'(up > 0 && up < 16), 20'h1, 0);
   endtask
   task automatic give_verdict();
      if (timed_out === 1'b1) bad_count++;
      if (bad_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // hang guard for the whole run
   initial begin
      repeat (60000) @(posedge core_clk);
      bad_count++;
      give_verdict();
   end
   // reset, load the table, then the scenarios
   initial begin
      reset_n = 1'b0;
      mode = MODE_TRUNC;
      tbl_we = 1'b0;
      tbl_addr = 12'h0;
      tbl_data = 18'h0;
      repeat (16) @(posedge core_clk);
      #2;
      chk({sin_out[18:0], out_valid}, 20'h0, 0);
      chk(20'(phase_ready), 20'h1, 0);
      reset_n = 1'b1;
      for (int i = 0; i < 4096; i++) begin
         tbl_we = 1'b1;
         tbl_addr = 12'(i);
         tbl_data = 18'(ent(i));
         @(posedge core_clk) #2;
      end
      tbl_we = 1'b0;
      burst(MODE_TRUNC, 32'hffd1_2345, 6, 0);
      fill();
      dith();
      burst(MODE_LINEAR, 32'h3fe7_ffff, 6, 2);
      burst(MODE_QUAD, 32'h8009_abcd, 6, 3);
      burst(MODE_TRUNC, 32'h0000_0000, 2, 0);
      give_verdict();
   end
endmodule // tb_dds_dither_taylor_correction
`default_nettype wire
